// File: rtl/nor_flash_bus_interface.sv
// Function
// - Word address width grows with density: A22 to A25 for 64 to 512 Mbit.
// - Lowest address input is the LSB; each step is one 16-bit word.
// - 512 Mbit dual die: top address bit high selects upper die.
// - Data bus captures writes internally and drives array, status or config on reads.
// - Data bus floats when die-select or output-gate is deasserted.
// - Sync read: address captured on address-valid rise or next clock edge while low.
// - Async: address latched on address-valid rise, flows through while low.
// - Die-select low keeps logic active; high means standby with outputs floating.
// - Host supplies bus clock in sync mode; device times sync reads to it.
// - Output-gate low enables data buffers; high floats data and wait.
// - Address and write data captured on write strobe rising edge.
// - Reset low clears automation, blocks writes; exit lands in async array read.
// - Wait flags invalid sync data; config bit 10 selects wait polarity.
`timescale 1ns/10ps
module nor_flash_bus_interface
  import nor_bus_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Configuration straps
  input  wire logic [1:0]           density,
  // Host bus
  input  wire logic [ADDR_MSB:ADDR_LSB] addr,
  input  wire logic                 die_select_n,
  input  wire logic                 output_gate_n,
  input  wire logic                 write_strobe_n,
  input  wire logic                 address_valid_n,
  input  wire logic                 bus_clk,
  input  wire logic                 sync_mode,
  // Data bus
  input  wire logic [DATA_W-1:0]    dq_in,
  output logic      [DATA_W-1:0]    dq_out,
  output logic                      dq_oe,
  // Wait pin
  output logic                      wait_out,
  output logic                      wait_oe,
  // Status
  output logic                      upper_die_sel,
  output logic                      standby
);
  logic [ADDR_MSB:ADDR_LSB] addr_reg;
  logic                     adv_n_reg;
  logic                     bclk_reg;
  logic                     we_n_reg;
  logic [ADDR_MSB:ADDR_LSB] waddr_reg;
  logic [DATA_W-1:0]        wdata_reg;
  logic                     wpend_reg;
  logic [CFG_W-1:0]         read_config_reg;
  read_mode_t               mode_reg;
  logic [1:0]               lat_reg;
  logic                     sync_cap_reg;
  logic [DATA_W-1:0]        dq_out_reg;
  logic                     dq_oe_reg;
  logic                     wait_reg;
  logic                     wait_oe_reg;
  logic                     upper_reg;
  logic                     standby_reg;
  logic [DATA_W-1:0]        rd_lo;
  logic [DATA_W-1:0]        rd_hi;

  // Density masks unused upper address lines
  wire [ADDR_MSB:ADDR_LSB] dens_mask =
    (density == DENS_64)  ? 25'h03FFFFF :
    (density == DENS_128) ? 25'h07FFFFF :
    (density == DENS_256) ? 25'h0FFFFFF : 25'h1FFFFFF;
  wire [ADDR_MSB:ADDR_LSB] addr_m = addr & dens_mask;
  wire selected   = ~die_select_n;
  wire adv_rise   = ~adv_n_reg & address_valid_n;
  wire bclk_rise  = ~bclk_reg & bus_clk;
  wire we_rise    = ~we_n_reg & write_strobe_n & selected;
  wire sync_take  = sync_mode && !address_valid_n && bclk_rise && !sync_cap_reg;
  wire addr_take  = adv_rise || sync_take;
  // Async flow-through while low or on the capture cycle, so no stale cycle follows
  wire [ADDR_MSB:ADDR_LSB] eff_addr =
    ((!sync_mode && !address_valid_n) || (addr_take && !sync_cap_reg)) ? addr_m : addr_reg;
  wire upper_sel  = (density == DENS_512) && eff_addr[ADDR_MSB];
  // Word index: A1 is the LSB of the array index
  wire [ARRAY_AW-1:0] word_idx = eff_addr[ARRAY_AW:ADDR_LSB];
  wire [ARRAY_AW-1:0] widx     = waddr_reg[ARRAY_AW:ADDR_LSB];
  wire wr_lo = wpend_reg && mode_reg == RD_ARRAY && !waddr_reg[ADDR_MSB];
  wire wr_hi = wpend_reg && mode_reg == RD_ARRAY && waddr_reg[ADDR_MSB] && density == DENS_512;
  wire [7:0] cmd  = wdata_reg[7:0];
  wire cmd_write  = wpend_reg && !(mode_reg == RD_ARRAY && cmd != CMD_READ_ARRAY &&
                    cmd != CMD_READ_CFG && cmd != CMD_SET_CFG && cmd != CMD_READ_STAT);
  wire [DATA_W-1:0] array_data = upper_sel ? rd_hi : rd_lo;
  wire [DATA_W-1:0] rd_data =
    (mode_reg == RD_CFG)    ? read_config_reg :
    (mode_reg == RD_STATUS) ? STATUS_READY : array_data;
  wire drive_en   = selected && !output_gate_n;
  wire data_ok    = !sync_mode || lat_reg == 2'(SYNC_LATENCY);
  wire wait_level = data_ok ? ~read_config_reg[WAIT_POL_POS]
                            :  read_config_reg[WAIT_POL_POS];

  nor_die_array u_lower (
    .clk     (clk),
    .wr_en   (wr_lo),
    .addr    (wr_lo ? widx : word_idx),
    .wr_data (wdata_reg),
    .rd_data (rd_lo)
  );

  nor_die_array u_upper (
    .clk     (clk),
    .wr_en   (wr_hi),
    .addr    (wr_hi ? widx : word_idx),
    .wr_data (wdata_reg),
    .rd_data (rd_hi)
  );

  // Pin edge history
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adv_n_reg <= 1'b1;
      bclk_reg  <= 1'b0;
      we_n_reg  <= 1'b1;
    end else begin
      adv_n_reg <= address_valid_n;
      bclk_reg  <= bus_clk;
      we_n_reg  <= write_strobe_n;
    end
  end

  // Address latch and sync capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_reg     <= '0;
      sync_cap_reg <= 1'b0;
    end else begin
      if (addr_take && !sync_cap_reg) begin
        addr_reg <= addr_m;
      end
      if (address_valid_n) begin
        sync_cap_reg <= 1'b0;
      end else if (sync_take) begin
        sync_cap_reg <= 1'b1;
      end
    end
  end

  // Write capture on strobe rise; reset blocks writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waddr_reg <= '0;
      wdata_reg <= '0;
      wpend_reg <= 1'b0;
    end else begin
      wpend_reg <= we_rise;
      if (we_rise) begin
        waddr_reg <= addr_m;
        wdata_reg <= dq_in;
      end
    end
  end

  // Command decode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_reg        <= RD_ARRAY;
      read_config_reg <= CFG_RESET;
    end else if (cmd_write) begin
      case (mode_reg)
        RD_SETUP: begin
          if (cmd == CMD_SET_CFG_OK) begin
            read_config_reg <= waddr_reg[CFG_W:ADDR_LSB];
          end
          mode_reg <= RD_ARRAY;
        end
        default: begin
          if (cmd == CMD_READ_CFG) begin
            mode_reg <= RD_CFG;
          end else if (cmd == CMD_READ_STAT) begin
            mode_reg <= RD_STATUS;
          end else if (cmd == CMD_SET_CFG) begin
            mode_reg <= RD_SETUP;
          end else begin
            mode_reg <= RD_ARRAY;
          end
        end
      endcase
    end
  end

  // Sync latency counter on bus clock edges
  always_ff @(posedge clk) begin
    if (!reset_n || !selected || addr_take) begin
      lat_reg <= LAT_RESET;
    end else if (bclk_rise && lat_reg != 2'(SYNC_LATENCY)) begin
      lat_reg <= lat_reg + 2'h1;
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dq_out_reg  <= 16'h0000;
      dq_oe_reg   <= 1'b0;
      wait_reg    <= 1'b0;
      wait_oe_reg <= 1'b0;
      upper_reg   <= 1'b0;
      standby_reg <= 1'b1;
    end else begin
      dq_out_reg  <= rd_data;
      dq_oe_reg   <= drive_en;
      wait_oe_reg <= drive_en;
      wait_reg    <= wait_level;
      upper_reg   <= upper_sel;
      standby_reg <= ~selected;
    end
  end

  assign dq_out        = dq_out_reg;
  assign dq_oe         = dq_oe_reg;
  assign wait_out      = wait_reg;
  assign wait_oe       = wait_oe_reg;
  assign upper_die_sel = upper_reg;
  assign standby       = standby_reg;

  property p_float;
    @(posedge clk) disable iff (!reset_n)
      (die_select_n || output_gate_n) |=> (!dq_oe && !wait_oe);
  endproperty
  a_float: assert property (p_float) else $error("Bus not floated");

  property p_drive;
    @(posedge clk) disable iff (!reset_n)
      (!die_select_n && !output_gate_n) |=> (dq_oe && wait_oe);
  endproperty
  a_drive: assert property (p_drive) else $error("Bus not driven");

  property p_standby;
    @(posedge clk) disable iff (!reset_n)
      die_select_n |=> standby;
  endproperty
  a_standby: assert property (p_standby) else $error("No standby");

  property p_adv_latch;
    @(posedge clk) disable iff (!reset_n)
      (adv_rise && !sync_cap_reg) |=> addr_reg == $past(addr_m);
  endproperty
  a_adv_latch: assert property (p_adv_latch) else $error("Address not latched");

  property p_wr_cap;
    @(posedge clk) disable iff (!reset_n)
      we_rise |=> (wdata_reg == $past(dq_in) && wpend_reg);
  endproperty
  a_wr_cap: assert property (p_wr_cap) else $error("Write not captured");

  property p_upper;
    @(posedge clk) disable iff (!reset_n)
      (density != DENS_512) |=> !upper_die_sel;
  endproperty
  a_upper: assert property (p_upper) else $error("Upper die outside 512");

  property p_wait_pol;
    @(posedge clk) disable iff (!reset_n)
      (!sync_mode) |=> wait_out == !$past(read_config_reg[WAIT_POL_POS]);
  endproperty
  a_wait_pol: assert property (p_wait_pol) else $error("Wait polarity wrong");

  property p_reset_mode;
    @(posedge clk) !reset_n |=> (mode_reg == RD_ARRAY && !wpend_reg);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("Reset mode wrong");

  property p_sync_take;
    @(posedge clk) disable iff (!reset_n)
      sync_take |=> (sync_cap_reg && addr_reg == $past(addr_m));
  endproperty
  a_sync_take: assert property (p_sync_take) else $error("Sync capture missed");

  sequence s_stat_cmd;
    we_rise ##1 (wpend_reg && mode_reg != RD_SETUP && cmd == CMD_READ_STAT);
  endsequence
  property p_cmd_apply;
    @(posedge clk) disable iff (!reset_n)
      s_stat_cmd |=> mode_reg == RD_STATUS;
  endproperty
  a_cmd_apply: assert property (p_cmd_apply) else $error("Command not applied");
endmodule

// File: rtl/nor_bus_pkg.sv
package nor_bus_pkg;
  localparam int ADDR_MSB      = 25;
  localparam int ADDR_LSB      = 1;
  localparam int DATA_W        = 16;
  localparam int ARRAY_AW      = 6;
  localparam int ARRAY_DEPTH   = 64;
  localparam int WAIT_POL_POS  = 10;
  localparam int CFG_W         = 16;
  localparam logic [15:0] CFG_RESET    = 16'h0400;
  localparam logic [1:0]  DENS_64      = 2'h0;
  localparam logic [1:0]  DENS_128     = 2'h1;
  localparam logic [1:0]  DENS_256     = 2'h2;
  localparam logic [1:0]  DENS_512     = 2'h3;
  localparam int SYNC_LATENCY  = 2;
  localparam logic [1:0]  LAT_RESET    = 2'h0;
  localparam logic [7:0]  CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0]  CMD_READ_CFG   = 8'h90;
  localparam logic [7:0]  CMD_SET_CFG    = 8'h60;
  localparam logic [7:0]  CMD_SET_CFG_OK = 8'h03;
  localparam logic [7:0]  CMD_READ_STAT  = 8'h70;
  localparam logic [15:0] STATUS_READY   = 16'h0080;
  typedef enum logic [1:0] {
    RD_ARRAY  = 2'b00,
    RD_CFG    = 2'b01,
    RD_STATUS = 2'b10,
    RD_SETUP  = 2'b11
  } read_mode_t;
endpackage

// File: rtl/nor_die_array.sv
`timescale 1ns/10ps
module nor_die_array
  import nor_bus_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Access
  input  wire logic                wr_en,
  input  wire logic [ARRAY_AW-1:0] addr,
  input  wire logic [DATA_W-1:0]   wr_data,
  output logic      [DATA_W-1:0]   rd_data
);
  logic [DATA_W-1:0] mem [ARRAY_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  assign rd_data = mem[addr];
endmodule

// File: sim/host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model
  import nor_bus_pkg::*;
(
  // Clock
  input  wire logic                     clk,
  // Host bus
  output logic [ADDR_MSB:ADDR_LSB]      addr,
  output logic                          die_select_n,
  output logic                          output_gate_n,
  output logic                          write_strobe_n,
  output logic                          address_valid_n,
  output logic                          bus_clk,
  output logic                          sync_mode,
  // Data bus
  output logic [DATA_W-1:0]             dq_in,
  input  wire logic [DATA_W-1:0]        dq_out,
  input  wire logic                     dq_oe
);
  logic [DATA_W-1:0] drv_dq;
  logic              drv_on;
  // Undriven wire shows the inverse of the last host value
  assign dq_in = drv_on ? drv_dq : (dq_oe ? dq_out : ~drv_dq);
  initial begin
    {drv_on, bus_clk, sync_mode, addr, drv_dq} = '0;
    {die_select_n, output_gate_n, write_strobe_n, address_valid_n} = 4'hF;
  end
  task automatic start(input logic [ADDR_MSB:ADDR_LSB] a, input logic sync);
    @(negedge clk);
    addr = a;
    sync_mode = sync;
    {die_select_n, output_gate_n, address_valid_n} = 3'h0;
  endtask
  task automatic stop();
    @(negedge clk);
    {die_select_n, output_gate_n, address_valid_n, sync_mode} = 4'hE;
    repeat (2) @(negedge clk);
  endtask
  // Bus clock runs only inside a synchronous read
  task automatic tick();
    @(negedge clk);
    bus_clk = 1'b1;
    repeat (2) @(negedge clk);
    bus_clk = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic write(input logic [ADDR_MSB:ADDR_LSB] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    {addr, drv_dq, drv_on} = {a, d, 1'b1};
    {die_select_n, address_valid_n, write_strobe_n} = 3'h0;
    repeat (2) @(negedge clk);
    write_strobe_n = 1'b1;
    repeat (2) @(negedge clk);
    {die_select_n, address_valid_n, drv_on} = 3'h6;
    repeat (2) @(negedge clk);
  endtask
endmodule

// File: sim/nor_flash_bus_interface_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module nor_flash_bus_interface_tb
  import nor_bus_pkg::*;
;
  logic                     clk;
  logic                     reset_n;
  logic [1:0]               density;
  logic [ADDR_MSB:ADDR_LSB] addr;
  logic                     die_select_n;
  logic                     output_gate_n;
  logic                     write_strobe_n;
  logic                     address_valid_n;
  logic                     bus_clk;
  logic                     sync_mode;
  logic [DATA_W-1:0]        dq_in;
  logic [DATA_W-1:0]        dq_out;
  logic                     dq_oe;
  logic                     wait_out;
  logic                     wait_oe;
  logic                     upper_die_sel;
  logic                     standby;
  int                       num_errors = 0;
  int                       num_checks = 0;
  nor_flash_bus_interface nor_flash_bus_interface_inst (.clk(clk), .reset_n(reset_n), .density(density),
    .addr(addr), .die_select_n(die_select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
    .address_valid_n(address_valid_n), .bus_clk(bus_clk), .sync_mode(sync_mode), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out), .wait_oe(wait_oe), .upper_die_sel(upper_die_sel),
    .standby(standby));
  host_bus_model host_bus_model_inst (.clk(clk), .addr(addr), .die_select_n(die_select_n),
    .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .address_valid_n(address_valid_n),
    .bus_clk(bus_clk), .sync_mode(sync_mode), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic reset_values();
    `CHK({dq_oe, wait_oe, standby, upper_die_sel, dq_out}, {4'h2, 16'h0000})
  endtask
  task automatic select_gating();
    host_bus_model_inst.start('0, 1'b0);
    repeat (2) @(negedge clk);
    `CHK({dq_oe, wait_oe, wait_out, standby}, 4'hC)
    host_bus_model_inst.output_gate_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({dq_oe, wait_oe, standby}, 3'h0)
    host_bus_model_inst.stop();
    `CHK({dq_oe, wait_oe, standby}, 3'h1)
  endtask
  task automatic status_read();
    host_bus_model_inst.write('0, {8'h00, CMD_READ_STAT});
    host_bus_model_inst.start('0, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(dq_out, STATUS_READY)
    host_bus_model_inst.stop();
    host_bus_model_inst.write('0, {8'h00, CMD_READ_ARRAY});
  endtask
  task automatic upper_die();
    density = DENS_512;
    host_bus_model_inst.start({1'b1, 24'h000000}, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(upper_die_sel, 1'b1)
    host_bus_model_inst.address_valid_n = 1'b1;
    repeat (2) @(negedge clk);
    host_bus_model_inst.addr = '0;
    repeat (2) @(negedge clk);
    `CHK(upper_die_sel, 1'b1)
    host_bus_model_inst.address_valid_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(upper_die_sel, 1'b0)
    {density, host_bus_model_inst.addr} = {DENS_256, 1'b1, 24'h000000};
    repeat (2) @(negedge clk);
    `CHK(upper_die_sel, 1'b0)
    host_bus_model_inst.stop();
  endtask
  task automatic sync_wait();
    host_bus_model_inst.start('0, 1'b1);
    host_bus_model_inst.tick();
    `CHK({wait_oe, wait_out}, 2'h3)
    host_bus_model_inst.tick();
    host_bus_model_inst.tick();
    `CHK({wait_oe, wait_out}, 2'h2)
    host_bus_model_inst.stop();
  endtask
  task automatic array_rw();
    density = DENS_512;
    host_bus_model_inst.write(25'h0000001, 16'h5A3C);
    host_bus_model_inst.write(25'h0000002, 16'hC3A5);
    host_bus_model_inst.write({1'b1, 24'h000001}, 16'h9E17);
    host_bus_model_inst.start(25'h0000001, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(dq_out, 16'h5A3C)
    host_bus_model_inst.addr = 25'h0000002;
    repeat (2) @(negedge clk);
    `CHK(dq_out, 16'hC3A5)
    host_bus_model_inst.addr = {1'b1, 24'h000001};
    repeat (2) @(negedge clk);
    `CHK({upper_die_sel, dq_out}, {1'b1, 16'h9E17})
    host_bus_model_inst.stop();
  endtask
  task automatic config_reset();
    host_bus_model_inst.write('0, {8'h00, CMD_SET_CFG});
    host_bus_model_inst.write(25'h0000123, {8'h00, CMD_SET_CFG_OK});
    host_bus_model_inst.write('0, {8'h00, CMD_READ_CFG});
    host_bus_model_inst.start('0, 1'b0);
    repeat (2) @(negedge clk);
    `CHK({wait_oe, wait_out, dq_out}, {2'h3, 16'h0123})
    host_bus_model_inst.stop();
    reset_n = 1'b0;
    host_bus_model_inst.write('0, {8'h00, CMD_READ_STAT});
    reset_values();
    reset_n = 1'b1;
    host_bus_model_inst.start(25'h0000001, 1'b0);
    repeat (2) @(negedge clk);
    `CHK({wait_oe, wait_out, dq_out}, {2'h2, 16'h5A3C})
    host_bus_model_inst.stop();
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {reset_n, density} = {1'b0, DENS_64};
    repeat (10) @(negedge clk);
    reset_values();
    reset_n = 1'b1;
    select_gating();
    status_read();
    upper_die();
    sync_wait();
    array_rw();
    config_reset();
    print_verdict();
  end
endmodule
